// ---- core/prpf_root_port.sv ----
// Root port feature logic: sleep handshake, latency reports, debug port decode, routing
//
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/1ps
//
// Contract
// - Sleep request makes every port send turn-off
// - Endpoint acks, then requests L23 entry
// - Received turn-off ack causes no action
// - Sleep entry proceeds only after L23 reached
// - Latency reports accepted, passed to power manager
// - Endpoint reports latency at boot and change
// - Enabled port claims I/O 80h through 8Fh
// - Claim ignores I/O window and enable
// - Claimed debug cycles forwarded unmodified
// - Endpoint reads back last written value
// - Firmware enables claim on one port only
// - Spread mode tolerates about 5600 ppm offset
// - Separate clock mode is a static strap
// - No ASPM L0s in separate clock mode
// - L1 exit latency reports 10 us separately
// - No reduced-rate SKP generation or acceptance
// - Basic error handling with advanced reporting; code keeps only an unsupported-request flag in bit 0 of REG_ERR
// - Alternative routing-ID allows many functions
// - Access control routes, blocks or redirects TLPs
// - Never start width change; honour endpoint changes
// - Peer memory reads refused, writes allowed
// - Clock-request hot-plug, no containment, VC0 only
module prpf_root_port #(
   parameter int P_ACS_FUNCS = 256
) (
   input  wire logic                        i_core_clk,
   input  wire logic                        i_rst,
   input  wire logic                        i_sep_clk_strap,
   input  wire logic                        i_clkreq_n,
   // Fabric request toward the downstream link
   input  wire logic                        i_req_valid,
   input  wire prpf_pkg::prpf_tlp_t         i_req_kind,
   input  wire logic [prpf_pkg::ADDR_W-1:0] i_req_addr,
   input  wire logic [prpf_pkg::DATA_W-1:0] i_req_data,
   input  wire logic                        i_req_peer,
   input  wire logic [prpf_pkg::ARI_FUNC_W-1:0] i_req_func,
   input  wire logic [prpf_pkg::ADDR_W-1:0] i_io_base,
   input  wire logic [prpf_pkg::ADDR_W-1:0] i_io_limit,
   input  wire logic                        i_io_space_en,
   output logic                             o_req_blocked,
   output logic                             o_req_redirect,
   output logic                             o_rd_valid,
   output logic      [prpf_pkg::DATA_W-1:0] o_rd_data,
   output logic                             o_sx_proceed,
   output logic                             o_hotplug,
   // Wishbone classic slave
   input  wire logic                        i_wb_cyc,
   input  wire logic                        i_wb_stb,
   input  wire logic                        i_wb_we,
   input  wire logic [7:0]                  i_wb_adr,
   input  wire logic [3:0]                  i_wb_sel,
   input  wire logic [31:0]                 i_wb_dat,
   output logic      [31:0]                 o_wb_dat,
   output logic                             o_wb_ack,
   prpf_link_if.rp                          link
);
   if (P_ACS_FUNCS < 1 || P_ACS_FUNCS > 256) begin : g_bad_funcs
      $error("P_ACS_FUNCS out of range");
   end

   // Per-function access control: 0 route, 1 block, 2 redirect
   logic [1:0]                  acs_reg [P_ACS_FUNCS];
   logic                        dbg_en_reg, dbg_en_next;
   logic                        sep_reg, sep_next;
   logic                        strap_done_reg, strap_done_next;
   prpf_pkg::prpf_pm_t          pm_reg, pm_next;
   logic [prpf_pkg::LTR_W-1:0]  ltr_reg, ltr_next;
   logic [7:0]                  err_reg, err_next;
   logic                        spd_reg, spd_next;
   logic                        sx_reg, sx_next;
   logic [1:0]                  chg_reg, chg_next;
   logic                        dv_reg, dv_next;
   prpf_pkg::prpf_tlp_t         dk_reg, dk_next;
   logic [prpf_pkg::ADDR_W-1:0] da_reg, da_next;
   logic [prpf_pkg::DATA_W-1:0] dd_reg, dd_next;
   prpf_pkg::prpf_msg_t         dm_reg, dm_next;
   logic                        blk_reg, blk_next, red_reg, red_next;
   logic                        rv_reg, rv_next;
   logic [prpf_pkg::DATA_W-1:0] rdat_reg, rdat_next;
   logic                        hp_reg, hp_next;
   logic [31:0]                 wbd_reg, wbd_next;
   logic                        ack_reg, ack_next;
   logic                        wb_hit, dbg_hit, win_hit, fwd;
   prpf_pkg::prpf_acs_t         acs_sel;

   assign wb_hit  = i_wb_cyc && i_wb_stb && !ack_reg;
   assign dbg_hit = dbg_en_reg && i_req_addr >= prpf_pkg::DBG_PORT_LO
                    && i_req_addr <= prpf_pkg::DBG_PORT_HI;
   assign win_hit = i_io_space_en && i_req_addr >= i_io_base && i_req_addr <= i_io_limit;
   assign acs_sel = prpf_pkg::prpf_acs_t'(acs_reg[i_req_func]);

   always_comb begin
      dbg_en_next     = dbg_en_reg;
      sep_next        = sep_reg;
      strap_done_next = 1'b1;
      pm_next         = pm_reg;
      ltr_next        = ltr_reg;
      err_next        = err_reg;
      spd_next        = 1'b0;
      chg_next        = chg_reg;
      dv_next         = 1'b0;
      dk_next         = dk_reg;
      da_next         = da_reg;
      dd_next         = dd_reg;
      dm_next         = prpf_pkg::PRPF_MSG_NONE;
      blk_next        = 1'b0;
      red_next        = 1'b0;
      rv_next         = link.up_valid;
      rdat_next       = link.up_data;
      hp_next         = !i_clkreq_n; // Presence via clock request
      wbd_next        = 32'h0000_0000;
      ack_next        = wb_hit;
      fwd             = 1'b0;
      // Strap caught once after reset, then frozen
      if (!strap_done_reg) begin
         sep_next = i_sep_clk_strap;
      end
      // Forward with no alteration; debug port claim bypasses window and enable
      if (i_req_valid) begin
         case (i_req_kind)
            prpf_pkg::PRPF_TLP_IO_RD, prpf_pkg::PRPF_TLP_IO_WR: begin
               fwd = dbg_hit || win_hit;
            end
            prpf_pkg::PRPF_TLP_MEM_RD: begin
               fwd = !i_req_peer;
            end
            default: begin
               fwd = 1'b1;
            end
         endcase
         if (fwd && acs_sel == prpf_pkg::PRPF_ACS_BLOCK) begin
            blk_next = 1'b1;
         end else if (fwd && acs_sel == prpf_pkg::PRPF_ACS_REDIRECT && i_req_peer) begin
            red_next = 1'b1;
         end else if (fwd) begin
            dv_next = 1'b1;
            dk_next = i_req_kind;
            da_next = i_req_addr;
            dd_next = i_req_data;
         end else begin
            blk_next = 1'b1;
            err_next[0] = 1'b1; // Unsupported request logged
         end
      end
      // Sleep handshake
      case (pm_reg)
         prpf_pkg::PRPF_PM_RUN: begin
            if (wb_hit && i_wb_we && i_wb_adr == prpf_pkg::REG_CTRL && i_wb_sel[0]
                && i_wb_dat[prpf_pkg::CTRL_SX_REQ]) begin
               pm_next = prpf_pkg::PRPF_PM_TURN;
            end
         end
         prpf_pkg::PRPF_PM_TURN: begin
            dm_next = prpf_pkg::PRPF_MSG_TURN_OFF;
            pm_next = prpf_pkg::PRPF_PM_WAIT;
         end
         prpf_pkg::PRPF_PM_WAIT: begin
            if (link.in_l23) begin
               pm_next = prpf_pkg::PRPF_PM_DONE;
            end
         end
         prpf_pkg::PRPF_PM_DONE: begin
            pm_next = prpf_pkg::PRPF_PM_DONE;
         end
         default: begin
            pm_next = prpf_pkg::PRPF_PM_RUN;
         end
      endcase
      sx_next = (pm_next == prpf_pkg::PRPF_PM_DONE);
      // Turn-off ack deliberately ignored
      case (link.up_msg)
         prpf_pkg::PRPF_MSG_LTR: begin
            ltr_next = link.up_ltr;
         end
         prpf_pkg::PRPF_MSG_WIDTH, prpf_pkg::PRPF_MSG_SPEED: begin
            chg_next = chg_reg + 2'h1; // Endpoint-led change honoured
         end
         default: begin
            chg_next = chg_reg;
         end
      endcase
      // Only speed changes may be started here; width never
      if (wb_hit && i_wb_we && i_wb_adr == prpf_pkg::REG_CTRL && i_wb_sel[0]) begin
         dbg_en_next = i_wb_dat[prpf_pkg::CTRL_DBG_EN];
         spd_next    = i_wb_dat[prpf_pkg::CTRL_SPEED_REQ];
         if (i_wb_dat[prpf_pkg::CTRL_ERR_CLR]) begin
            err_next[0] = 1'b0;
         end
      end
      if (spd_reg && pm_reg == prpf_pkg::PRPF_PM_RUN && dm_next == prpf_pkg::PRPF_MSG_NONE) begin
         dm_next = prpf_pkg::PRPF_MSG_SPEED;
      end
      // Set beats clear for the error flag
      if (i_req_valid && !fwd) begin
         err_next[0] = 1'b1;
      end
      if (wb_hit && !i_wb_we) begin
         case (i_wb_adr)
            prpf_pkg::REG_CTRL:   wbd_next = {31'h0, dbg_en_reg};
            prpf_pkg::REG_STATUS: wbd_next = {26'h0, chg_reg, hp_reg, sep_reg, pm_reg};
            prpf_pkg::REG_LTR:    wbd_next = {16'h0, ltr_reg};
            prpf_pkg::REG_ERR:    wbd_next = {24'h0, err_reg};
            // Caps: VC id, L0s only without separate clock / no reduced SKP / no containment, L1 exit us
            prpf_pkg::REG_CAPS:   wbd_next = {16'h0, 6'h0, prpf_pkg::VC_ID_ONLY,
                                   2'h0, !sep_reg, 1'b0,
                                   sep_reg ? 4'(prpf_pkg::L1_EXIT_US_SEP)
                                           : 4'(prpf_pkg::L1_EXIT_US_COM)};
            default:              wbd_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         dbg_en_reg     <= 1'b0;
         sep_reg        <= 1'b0;
         strap_done_reg <= 1'b0;
         pm_reg         <= prpf_pkg::PRPF_PM_RUN;
         ltr_reg        <= prpf_pkg::LTR_RESET;
         err_reg        <= 8'h00;
         spd_reg        <= 1'b0;
         sx_reg         <= 1'b0;
         chg_reg        <= 2'h0;
         dv_reg         <= 1'b0;
         dk_reg         <= prpf_pkg::PRPF_TLP_IO_RD;
         da_reg         <= 16'h0000;
         dd_reg         <= 8'h00;
         dm_reg         <= prpf_pkg::PRPF_MSG_NONE;
         blk_reg        <= 1'b0;
         red_reg        <= 1'b0;
         rv_reg         <= 1'b0;
         rdat_reg       <= 8'h00;
         hp_reg         <= 1'b0;
         wbd_reg        <= 32'h0000_0000;
         ack_reg        <= 1'b0;
      end else begin
         dbg_en_reg     <= dbg_en_next;
         sep_reg        <= sep_next;
         strap_done_reg <= strap_done_next;
         pm_reg         <= pm_next;
         ltr_reg        <= ltr_next;
         err_reg        <= err_next;
         spd_reg        <= spd_next;
         sx_reg         <= sx_next;
         chg_reg        <= chg_next;
         dv_reg         <= dv_next;
         dk_reg         <= dk_next;
         da_reg         <= da_next;
         dd_reg         <= dd_next;
         dm_reg         <= dm_next;
         blk_reg        <= blk_next;
         red_reg        <= red_next;
         rv_reg         <= rv_next;
         rdat_reg       <= rdat_next;
         hp_reg         <= hp_next;
         wbd_reg        <= wbd_next;
         ack_reg        <= ack_next;
      end
   end

   // ACS table reset to route-normally; writes through REG_ACS, function index in data bits 15:8
   genvar g;
   for (g = 0; g < P_ACS_FUNCS; g++) begin : g_acs
      always_ff @(posedge i_core_clk) begin
         if (i_rst) begin
            acs_reg[g] <= 2'h0;
         end else if (wb_hit && i_wb_we && i_wb_adr == prpf_pkg::REG_ACS
                      && i_wb_dat[15:8] == 8'(g)) begin
            acs_reg[g] <= i_wb_dat[1:0];
         end
      end
   end

   // Spread-spectrum tolerance is analog; mode is only exported
   assign link.sep_clk_mode = sep_reg;
   assign link.dn_valid = dv_reg;
   assign link.dn_kind  = dk_reg;
   assign link.dn_addr  = da_reg;
   assign link.dn_data  = dd_reg;
   assign link.dn_msg   = dm_reg;
   assign o_req_blocked  = blk_reg;
   assign o_req_redirect = red_reg;
   assign o_rd_valid     = rv_reg;
   assign o_rd_data      = rdat_reg;
   assign o_sx_proceed   = sx_reg;
   assign o_hotplug      = hp_reg;
   assign o_wb_dat       = wbd_reg;
   assign o_wb_ack       = ack_reg;
endmodule // prpf_root_port

// ---- core/prpf_pkg.sv ----
// Shared constants and types for the root port feature block and its endpoint model
package prpf_pkg;
   localparam int          ADDR_W          = 16;
   localparam int          DATA_W          = 8;
   localparam logic [15:0] DBG_PORT_LO     = 16'h0080;
   localparam logic [15:0] DBG_PORT_HI     = 16'h008f;
   localparam int          LTR_W           = 16;
   localparam logic [15:0] LTR_RESET       = 16'hffff;
   localparam int          PPM_COMMON      = 600;
   localparam int          PPM_SPREAD      = 5600;
   localparam int          L1_EXIT_US_SEP  = 10;
   localparam int          L1_EXIT_US_COM  = 2;
   localparam logic [1:0]  VC_ID_ONLY      = 2'h0;
   localparam int          ARI_FUNC_W      = 8;
   // Wishbone register offsets (byte addresses)
   localparam logic [7:0]  REG_CTRL        = 8'h00;
   localparam logic [7:0]  REG_STATUS      = 8'h04;
   localparam logic [7:0]  REG_LTR         = 8'h08;
   localparam logic [7:0]  REG_ERR         = 8'h0c;
   localparam logic [7:0]  REG_CAPS        = 8'h10;
   localparam logic [7:0]  REG_ACS         = 8'h14;
   // Control register fields
   localparam int          CTRL_DBG_EN     = 0;
   localparam int          CTRL_SX_REQ     = 1;
   localparam int          CTRL_SPEED_REQ  = 2;
   localparam int          CTRL_ERR_CLR    = 3;
   // Link messages
   typedef enum logic [2:0] {
      PRPF_MSG_NONE     = 3'h0,
      PRPF_MSG_TURN_OFF = 3'h1,
      PRPF_MSG_TO_ACK   = 3'h2,
      PRPF_MSG_ENTER_L23= 3'h3,
      PRPF_MSG_LTR      = 3'h4,
      PRPF_MSG_WIDTH    = 3'h5,
      PRPF_MSG_SPEED    = 3'h6
   } prpf_msg_t;
   // Forwarded TLP kinds
   typedef enum logic [2:0] {
      PRPF_TLP_IO_RD  = 3'h0,
      PRPF_TLP_IO_WR  = 3'h1,
      PRPF_TLP_MEM_RD = 3'h2,
      PRPF_TLP_MEM_WR = 3'h3,
      PRPF_TLP_CPL    = 3'h4
   } prpf_tlp_t;
   typedef enum logic [1:0] {
      PRPF_ACS_ROUTE    = 2'h0,
      PRPF_ACS_BLOCK    = 2'h1,
      PRPF_ACS_REDIRECT = 2'h2
   } prpf_acs_t;
   typedef enum logic [1:0] {
      PRPF_PM_RUN  = 2'h0,
      PRPF_PM_TURN = 2'h1,
      PRPF_PM_WAIT = 2'h2,
      PRPF_PM_DONE = 2'h3
   } prpf_pm_t;
endpackage

// ---- core/prpf_link_if.sv ----
// Link between root port and downstream endpoint
`timescale 1ns/1ps
interface prpf_link_if;
   logic                        dn_valid;
   prpf_pkg::prpf_tlp_t         dn_kind;
   logic [prpf_pkg::ADDR_W-1:0] dn_addr;
   logic [prpf_pkg::DATA_W-1:0] dn_data;
   logic                        up_valid;
   logic [prpf_pkg::DATA_W-1:0] up_data;
   prpf_pkg::prpf_msg_t         dn_msg;
   prpf_pkg::prpf_msg_t         up_msg;
   logic [prpf_pkg::LTR_W-1:0]  up_ltr;
   logic                        sep_clk_mode;
   logic                        in_l23;
   modport rp (output dn_valid, dn_kind, dn_addr, dn_data, dn_msg, sep_clk_mode,
               input up_valid, up_data, up_msg, up_ltr, in_l23);
   modport ep (input dn_valid, dn_kind, dn_addr, dn_data, dn_msg, sep_clk_mode,
               output up_valid, up_data, up_msg, up_ltr, in_l23);
endinterface

// ---- core/prpf_endpoint.sv ----
// Downstream endpoint end of the root port link
`timescale 1ns/1ps
module prpf_endpoint (
   input  wire logic                        i_core_clk,
   input  wire logic                        i_rst,
   prpf_link_if.ep                          link,
   input  wire logic                        i_ltr_send,
   input  wire logic [prpf_pkg::LTR_W-1:0]  i_ltr_value,
   output logic      [prpf_pkg::DATA_W-1:0] o_dbg_last,
   output logic                             o_in_l23
);
   logic [prpf_pkg::DATA_W-1:0] dbg_reg, dbg_next;
   logic                        rd_reg, rd_next;
   logic [1:0]                  pm_reg, pm_next;
   logic                        boot_reg, boot_next;
   prpf_pkg::prpf_msg_t         msg_reg, msg_next;
   logic [prpf_pkg::LTR_W-1:0]  ltr_reg, ltr_next;

   always_comb begin
      dbg_next  = dbg_reg;
      rd_next   = 1'b0;
      pm_next   = pm_reg;
      boot_next = 1'b1;
      msg_next  = prpf_pkg::PRPF_MSG_NONE;
      ltr_next  = ltr_reg;
      if (link.dn_valid && link.dn_kind == prpf_pkg::PRPF_TLP_IO_WR) begin
         dbg_next = link.dn_data;
      end
      if (link.dn_valid && link.dn_kind == prpf_pkg::PRPF_TLP_IO_RD) begin
         rd_next = 1'b1; // Return last written value
      end
      // Acknowledge, then request L23 on the following cycle
      if (pm_reg == 2'h0 && link.dn_msg == prpf_pkg::PRPF_MSG_TURN_OFF) begin
         msg_next = prpf_pkg::PRPF_MSG_TO_ACK;
         pm_next  = 2'h1;
      end else if (pm_reg == 2'h1) begin
         msg_next = prpf_pkg::PRPF_MSG_ENTER_L23;
         pm_next  = 2'h2;
      end else if (pm_reg == 2'h0 && (!boot_reg || i_ltr_send)) begin
         msg_next = prpf_pkg::PRPF_MSG_LTR; // Boot and on change
         // Boot report carries the tolerance already presented
         if (i_ltr_send || !boot_reg) begin
            ltr_next = i_ltr_value;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         dbg_reg  <= 8'h00;
         rd_reg   <= 1'b0;
         pm_reg   <= 2'h0;
         boot_reg <= 1'b0;
         msg_reg  <= prpf_pkg::PRPF_MSG_NONE;
         ltr_reg  <= prpf_pkg::LTR_RESET;
      end else begin
         dbg_reg  <= dbg_next;
         rd_reg   <= rd_next;
         pm_reg   <= pm_next;
         boot_reg <= boot_next;
         msg_reg  <= msg_next;
         ltr_reg  <= ltr_next;
      end
   end

   assign link.up_valid = rd_reg;
   assign link.up_data  = dbg_reg;
   assign link.up_msg   = msg_reg;
   assign link.up_ltr   = ltr_reg;
   assign link.in_l23   = (pm_reg == 2'h2);
   assign o_dbg_last    = dbg_reg;
   assign o_in_l23      = (pm_reg == 2'h2);
endmodule // prpf_endpoint

// ---- dv/prpf_link_properties.sv ----
// Concurrent checks on the link between root port and endpoint
`timescale 1ns/1ps
module prpf_link_properties (
   input wire logic                i_core_clk,
   input wire logic                i_rst,
   input wire logic                i_req_valid,
   input wire logic [15:0]         i_req_addr,
   input wire logic [7:0]          i_req_data,
   input wire logic                dn_valid,
   input wire logic [15:0]         dn_addr,
   input wire logic [7:0]          dn_data,
   input wire prpf_pkg::prpf_msg_t dn_msg,
   input wire prpf_pkg::prpf_msg_t up_msg,
   input wire logic                up_valid,
   input wire logic [7:0]          up_data,
   input wire logic                in_l23,
   input wire logic                o_rd_valid,
   input wire logic [7:0]          o_rd_data,
   input wire logic                o_sx_proceed
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   property p_ack_follows;
      dn_msg == prpf_pkg::PRPF_MSG_TURN_OFF |-> ##[1:8] up_msg == prpf_pkg::PRPF_MSG_TO_ACK;
   endproperty
   a_ack_follows: assert property (p_ack_follows) else $error("no turn-off ack");
   property p_l23_req;
      up_msg == prpf_pkg::PRPF_MSG_TO_ACK |-> ##[1:8] up_msg == prpf_pkg::PRPF_MSG_ENTER_L23;
   endproperty
   a_l23_req: assert property (p_l23_req) else $error("no L23 request");
   property p_ack_ignored;
      up_msg == prpf_pkg::PRPF_MSG_TO_ACK |=> dn_msg == prpf_pkg::PRPF_MSG_NONE && !dn_valid;
   endproperty
   a_ack_ignored: assert property (p_ack_ignored) else $error("reaction to ack");
   property p_sx_wait;
      !in_l23 && !o_sx_proceed |=> !o_sx_proceed;
   endproperty
   a_sx_wait: assert property (p_sx_wait) else $error("sleep went on early");
   property p_sx_go;
      in_l23 |=> o_sx_proceed;
   endproperty
   a_sx_go: assert property (p_sx_go) else $error("sleep did not go on");
   property p_no_width;
      dn_msg != prpf_pkg::PRPF_MSG_WIDTH;
   endproperty
   a_no_width: assert property (p_no_width) else $error("width change sent");
   property p_fwd_same;
      dn_valid |-> $past(i_req_valid) && dn_addr == $past(i_req_addr)
         && dn_data == $past(i_req_data);
   endproperty
   a_fwd_same: assert property (p_fwd_same) else $error("forward altered");
   property p_rd_return;
      up_valid |=> o_rd_valid && o_rd_data == $past(up_data);
   endproperty
   a_rd_return: assert property (p_rd_return) else $error("read return lost");
endmodule // prpf_link_properties

// ---- dv/pcie_root_port_features_tb.sv ----
// Self-checking bench: root port and endpoint joined by their link
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD %s exp %h got %h", nm, (e), (g)); end end
module pcie_root_port_features_tb;
   logic clk = 1'b0, rst = 1'b1, strap = 1'b0, clkreq_n = 1'b1, rq_v = 1'b0, rq_p = 1'b0;
   logic io_en = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ltr_send = 1'b0;
   logic ack, blocked, redirect, rd_valid, sx_proceed, hotplug, in_l23;
   logic [15:0] rq_a = 16'h0, ltr_val = 16'h0;
   logic [7:0] rq_d = 8'h0, rq_f = 8'h0, adr = 8'h0, rd_data, dbg_last;
   logic [31:0] wdat = 32'h0, rdat, rdv;
   logic [3:0] sel = 4'h0;
   prpf_pkg::prpf_tlp_t rq_k = prpf_pkg::PRPF_TLP_MEM_WR;
   logic [15:0] io_tab [7] = '{16'h1000, 16'h10ff, 16'h1100, 16'h7f, 16'h80, 16'h8f, 16'h90};
   int bad_count, checks, seed, cycles, last_wr, acs_func, acs_mode, n;
   bit dbg_en;
   prpf_link_if link ();
   prpf_root_port prpf_root_port_i (.i_core_clk(clk), .i_rst(rst), .i_sep_clk_strap(strap),
      .i_clkreq_n(clkreq_n), .i_req_valid(rq_v), .i_req_kind(rq_k), .i_req_addr(rq_a),
      .i_req_data(rq_d), .i_req_peer(rq_p), .i_req_func(rq_f), .i_io_base(16'h1000),
      .i_io_limit(16'h10ff), .i_io_space_en(io_en), .o_req_blocked(blocked),
      .o_req_redirect(redirect), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
      .o_sx_proceed(sx_proceed), .o_hotplug(hotplug), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .link(link));
   prpf_endpoint prpf_endpoint_i (.i_core_clk(clk), .i_rst(rst), .link(link),
      .i_ltr_send(ltr_send), .i_ltr_value(ltr_val), .o_dbg_last(dbg_last), .o_in_l23(in_l23));
   prpf_link_properties prpf_link_properties_i (.i_core_clk(clk), .i_rst(rst),
      .i_req_valid(rq_v), .i_req_addr(rq_a), .i_req_data(rq_d), .dn_valid(link.dn_valid),
      .dn_addr(link.dn_addr), .dn_data(link.dn_data), .dn_msg(link.dn_msg),
      .up_msg(link.up_msg), .up_valid(link.up_valid), .up_data(link.up_data),
      .in_l23(link.in_l23), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
      .o_sx_proceed(sx_proceed));
   initial begin
      forever #4 clk = ~clk;
   end
   // Whole run needs a few hundred cycles; the ceiling leaves wide margin
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Expected fate of a request: 0 forwarded, 1 blocked, 2 redirected
   function automatic int model(prpf_pkg::prpf_tlp_t k, logic [15:0] a, logic p, logic [7:0] f);
      if (k == prpf_pkg::PRPF_TLP_IO_RD || k == prpf_pkg::PRPF_TLP_IO_WR)
         return ((dbg_en && a >= prpf_pkg::DBG_PORT_LO && a <= prpf_pkg::DBG_PORT_HI)
            || (io_en && a >= 16'h1000 && a <= 16'h10ff)) ? 0 : 1;
      if (p && k == prpf_pkg::PRPF_TLP_MEM_RD)
         return 1;
      if (f == acs_func && acs_mode == 1)
         return 1;
      return (f == acs_func && acs_mode == 2 && p) ? 2 : 0;
   endfunction
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      sel <= 4'hf;
      we <= w;
      adr <= a;
      wdat <= d;
      // Only the bench timeout ends a wait for the answer
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rdv = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic req(input prpf_pkg::prpf_tlp_t k, input logic [15:0] a, input logic p,
                      input logic [7:0] f);
      int e;
      logic [7:0] d;
      e = model(k, a, p, f);
      d = 8'($random(seed));
      @(posedge clk);
      rq_v <= 1'b1;
      rq_k <= k;
      rq_a <= a;
      rq_d <= d;
      rq_p <= p;
      rq_f <= f;
      @(posedge clk);
      rq_v <= 1'b0;
      @(posedge clk);
      `CHK("fwd", e == 0, link.dn_valid)
      `CHK("blk", e == 1, blocked)
      `CHK("redir", e == 2, redirect)
      if (e == 0) begin
         `CHK("kind", k, link.dn_kind)
         if (k == prpf_pkg::PRPF_TLP_IO_WR)
            last_wr = d;
      end
   endtask
   task automatic wait_msg(input prpf_pkg::prpf_msg_t m);
      n = 0;
      while (link.dn_msg !== m && n < 16) begin
         @(posedge clk);
         n++;
      end
      `CHK("msg", m, link.dn_msg)
   endtask
   initial begin
      seed = 14;
      for (int s = 0; s < 2; s++) begin
         @(posedge clk);
         rst <= 1'b1;
         strap <= s[0];
         ltr_val <= 16'($random(seed));
         repeat (8) @(posedge clk);
         rst <= 1'b0;
         dbg_en = 0;
         acs_func = 0;
         acs_mode = 0;
         repeat (4) @(posedge clk);
         wb(1'b0, prpf_pkg::REG_LTR, 32'h0);
         `CHK("boot ltr", ltr_val, rdv[15:0])
         wb(1'b0, prpf_pkg::REG_CTRL, 32'h0);
         `CHK("claim", 1'b0, rdv[0])
         wb(1'b0, prpf_pkg::REG_CAPS, 32'h0);
         n = s ? prpf_pkg::L1_EXIT_US_SEP : prpf_pkg::L1_EXIT_US_COM;
         `CHK("l1", 4'(n), rdv[3:0])
         `CHK("skp", 1'b0, rdv[4])
         `CHK("l0s", s == 0, rdv[5])
         `CHK("vc", prpf_pkg::VC_ID_ONLY, rdv[9:8])
         wb(1'b0, prpf_pkg::REG_STATUS, 32'h0);
         `CHK("sep", s[0], rdv[2])
         if (s == 0) begin
            wb(1'b0, 8'h18, 32'h0);
            `CHK("unmapped", 32'h0, rdv)
            // All four window and claim settings against boundary addresses
            for (int m = 0; m < 4; m++) begin
               @(posedge clk);
               io_en <= m[0];
               dbg_en = m[1];
               wb(1'b1, prpf_pkg::REG_CTRL, {31'h0, m[1]});
               foreach (io_tab[j])
                  req(prpf_pkg::PRPF_TLP_IO_WR, io_tab[j], 1'b0, 8'h0);
            end
            req(prpf_pkg::PRPF_TLP_IO_RD, 16'h85, 1'b0, 8'h0);
            n = 0;
            while (rd_valid !== 1'b1 && n < 16) begin
               @(posedge clk);
               n++;
            end
            `CHK("rd", last_wr[7:0], rd_data)
            `CHK("ep last", last_wr[7:0], dbg_last)
            // Function index above eight exercises extended routing IDs
            for (int m = 0; m < 3; m++) begin
               acs_mode = m;
               acs_func = 8'hc5;
               wb(1'b1, prpf_pkg::REG_ACS, {16'h0, 8'hc5, 6'h0, 2'(m)});
               for (int p = 0; p < 2; p++) begin
                  req(prpf_pkg::PRPF_TLP_MEM_WR, 16'h2000, p[0], 8'hc5);
                  req(prpf_pkg::PRPF_TLP_MEM_RD, 16'h2000, p[0], 8'h03);
               end
            end
            wb(1'b0, prpf_pkg::REG_ERR, 32'h0);
            `CHK("ur", 1'b1, rdv[0])
            wb(1'b1, prpf_pkg::REG_CTRL, 32'h9);
            wb(1'b0, prpf_pkg::REG_ERR, 32'h0);
            `CHK("ur clr", 1'b0, rdv[0])
            repeat (3) begin
               @(posedge clk);
               ltr_val <= 16'($random(seed));
               ltr_send <= 1'b1;
               @(posedge clk);
               ltr_send <= 1'b0;
               repeat (4) @(posedge clk);
               wb(1'b0, prpf_pkg::REG_LTR, 32'h0);
               `CHK("ltr", ltr_val, rdv[15:0])
            end
            @(posedge clk);
            clkreq_n <= 1'b0;
            repeat (3) @(posedge clk);
            wb(1'b0, prpf_pkg::REG_STATUS, 32'h0);
            `CHK("hotplug", 1'b1, rdv[3])
            `CHK("hp pin", 1'b1, hotplug)
            clkreq_n <= 1'b1;
            wb(1'b1, prpf_pkg::REG_CTRL, 32'h4);
            wait_msg(prpf_pkg::PRPF_MSG_SPEED);
            wb(1'b1, prpf_pkg::REG_CTRL, 32'h2);
            wait_msg(prpf_pkg::PRPF_MSG_TURN_OFF);
            n = 0;
            while (sx_proceed !== 1'b1 && n < 32) begin
               @(posedge clk);
               n++;
            end
            `CHK("l23", 1'b1, in_l23)
            `CHK("sx", 1'b1, sx_proceed)
            wb(1'b0, prpf_pkg::REG_STATUS, 32'h0);
            `CHK("pm", prpf_pkg::PRPF_PM_DONE, rdv[1:0])
         end
      end
      conclude();
   end
endmodule // pcie_root_port_features_tb
